// ===== rtl/ccr_defines.vh
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH
`define CCR_ADDR_CTRL1 8'h01
`define CCR_ADDR_FAST_CHARGE_CURRENT_CODE_LIMIT 8'h02
`define CCR_ADDR_PRE_TERM 8'h03
`define CCR_RST_CTRL1 8'h1a
`define CCR_RST_FAST_CHARGE_CURRENT_CODE_LIMIT 8'ha2
`define CCR_RST_PRE_TERM 8'h22
`define CCR_BIT_LIGHT_LOAD 7
`define CCR_BIT_KICK 6
`define CCR_BIT_BOOST_EN 5
`define CCR_BIT_CHG_EN 4
`define CCR_BIT_BOOST_CURRENT_LIMIT_SELECT 7
`define CCR_BIT_Q1_FULL 6
`define CCR_PRECHG_MAX 4'hc
`define CCR_WDOG_OFF 2'h0
`define CCR_WDOG_40S 2'h1
`define CCR_WDOG_80S 2'h2
`define CCR_WDOG_160S 2'h3
`define CCR_WDOG_UNIT_CYCLES 40'd10000000000
`define CCR_WD_MASK_CTRL1 8'h70
`define CCR_WD_MASK_FAST_CHARGE_CURRENT_CODE 8'hbf
`define CCR_WD_MASK_PRE 8'hff
`define CCR_RST_LIGHT_LOAD 1'b0
`define CCR_RST_BOOST_EN 1'b0
`define CCR_RST_MIN_SYSTEM_VOLTAGE_CODE 3'h5
`define CCR_RST_BAT_SEL 1'b0
`define CCR_RST_BOOST_CURRENT_LIMIT_SELECT 1'b1
`define CCR_RST_FAST_CHARGE_CURRENT_CODE_CODE 6'h22
`define CCR_RST_PRE_CODE 4'h2
`define CCR_RST_TERM_CODE 4'h2
`define CCR_WDOG_PERIOD_S 40
`define CCR_CLK_MHZ 250
`endif

// ===== rtl/ccr_charger_control_registers.v
`timescale 1ns/1ns
`include "ccr_defines.vh"
// Operation
// - first control register resets to 0x1a
// - bit 7 forbids light-load mode when set; only register reset restores it
// - host writes 1 to kick bit in time; device restarts watchdog
// - kick bit clears itself after the watchdog restart
// - bit 5 enables boost output and overrides charge enable
// - charging needs bit 4 set and the active-low pin low
// - bits 3..1 pick minimum system voltage, default 101, register reset only
// - bit 0 selects boost low-battery falling threshold, 3 V or 2.57 V
// - charge current register resets to 0xa2
// - bit 7 selects boost current limit, restored by reset or watchdog
// - bits 5..0 fast-charge code, 60 mA per step, default 100010
// - fast-charge code zero disables charging
// - pre-charge/termination register resets to 0x22
// - bits 7..4 pre-charge code, 60 mA plus 60 mA per step
// - pre-charge codes above twelve are clamped to 1100
// - bits 3..0 termination code, all sixteen codes valid
// - watchdog period from two-bit field: off, 40 s, 80 s, 160 s
module ccr_charger_control_registers #(
  parameter [39:0] WDOG_UNIT_CYCLES = `CCR_WDOG_UNIT_CYCLES
) (
  input wire clk_i,
  input wire resetn_i,
  input wire reg_reset_i,
  input wire [7:0] addr_i,
  input wire wr_en_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire [1:0] watchdog_period_i,
  input wire charge_enable_pin_n_i,
  output reg watchdog_expired_o,
  output reg light_load_mode_disable_o,
  output reg boost_output_active_o,
  output reg charge_active_o,
  output reg [2:0] min_system_voltage_code_o,
  output reg boost_low_battery_threshold_select_o,
  output reg boost_current_limit_select_o,
  output reg [5:0] fast_charge_current_code_o,
  output reg [3:0] precharge_current_code_o,
  output reg [3:0] termination_current_code_o
);

  // architectural register storage
  reg [7:0] ctrl1;
  reg [7:0] fast_charge_current_code_limit;
  reg [7:0] pre_term;
  // next values of the storage
  reg [7:0] next_ctrl1;
  reg [7:0] next_fast_charge_current_code_limit;
  reg [7:0] next_pre_term;
  // watchdog state
  reg [39:0] wd_count;
  reg [39:0] next_wd_count;
  reg [39:0] wd_limit;
  reg kick_pending;
  reg next_expired;
  // charge-enable pin synchroniser
  reg pin_s1;
  reg pin_s2;
  reg pin_s3;
  reg pin_level;
  // decode and qualifier nets
  wire wr_ctrl1;
  wire wr_fast_charge_current_code;
  wire wr_pre;
  wire kick_wr;
  wire wd_enabled;
  wire wd_expire;
  wire wd_restore;
  wire [3:0] pre_clamped;
  wire chg_bit_on;
  wire chg_pin_on;
  wire chg_code_on;
  wire boost_on;
  wire chg_ok;

  // clamp pre-charge code to its top setting
  function [3:0] ccr_clamp_pre;
    input [3:0] code;
    begin
      if (code > `CCR_PRECHG_MAX) begin
        ccr_clamp_pre = `CCR_PRECHG_MAX;
      end else begin
        ccr_clamp_pre = code;
      end
    end
  endfunction

  // true for a write strobe aimed at the given register
  function ccr_write_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      ccr_write_hit = strobe && (addr == target);
    end
  endfunction

  // put the reset value back into the bits selected by the mask
  function [7:0] ccr_restore;
    input [7:0] cur;
    input [7:0] dflt;
    input [7:0] mask;
    begin
      ccr_restore = (cur & ~mask) | (dflt & mask);
    end
  endfunction

  // write decode, unmapped addresses hit nothing
  assign wr_ctrl1 = ccr_write_hit(wr_en_i, addr_i, `CCR_ADDR_CTRL1);
  assign wr_fast_charge_current_code = ccr_write_hit(wr_en_i, addr_i, `CCR_ADDR_FAST_CHARGE_CURRENT_CODE_LIMIT);
  assign wr_pre = ccr_write_hit(wr_en_i, addr_i, `CCR_ADDR_PRE_TERM);

  // a one written to the kick bit restarts the watchdog
  assign kick_wr = wr_ctrl1 && wdata_i[`CCR_BIT_KICK];

  // watchdog period: 1x, 2x or 4x the base unit, off gives zero
  always @* begin
    case (watchdog_period_i)
      `CCR_WDOG_OFF: begin
        wd_limit = 40'h0;
      end
      `CCR_WDOG_40S: begin
        wd_limit = WDOG_UNIT_CYCLES;
      end
      `CCR_WDOG_80S: begin
        wd_limit = {WDOG_UNIT_CYCLES[38:0], 1'b0};
      end
      `CCR_WDOG_160S: begin
        wd_limit = {WDOG_UNIT_CYCLES[37:0], 2'b00};
      end
      default: begin
        wd_limit = WDOG_UNIT_CYCLES;
      end
    endcase
  end

  // expiry on the last count of the period; a kick in that cycle wins
  assign wd_enabled = (wd_limit != 40'h0);
  assign wd_expire = wd_enabled && (wd_count >= wd_limit - 40'h1);
  assign wd_restore = wd_expire && !kick_wr;

  // next watchdog count: cleared by kick, expiry or a disabled period
  always @* begin
    if (kick_wr) begin
      next_wd_count = 40'h0;
    end else if (!wd_enabled) begin
      next_wd_count = 40'h0;
    end else if (wd_expire) begin
      next_wd_count = 40'h0;
    end else begin
      next_wd_count = wd_count + 40'h1;
    end
  end

  // sticky expiry flag: set by expiry, cleared by a kick
  always @* begin
    next_expired = watchdog_expired_o;
    if (wd_restore) begin
      next_expired = 1'b1;
    end else if (kick_wr) begin
      next_expired = 1'b0;
    end
  end

  // watchdog state, register reset restarts it
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wd_count <= 40'h0;
      kick_pending <= 1'b0;
      watchdog_expired_o <= 1'b0;
    end else if (reg_reset_i) begin
      wd_count <= 40'h0;
      kick_pending <= 1'b0;
      watchdog_expired_o <= 1'b0;
    end else begin
      wd_count <= next_wd_count;
      kick_pending <= kick_wr;
      watchdog_expired_o <= next_expired;
    end
  end

  // next control value: write, then kick self-clear, then expiry restore
  always @* begin
    next_ctrl1 = ctrl1;
    if (wr_ctrl1) begin
      next_ctrl1 = wdata_i;
    end else if (kick_pending) begin
      next_ctrl1[`CCR_BIT_KICK] = 1'b0;
    end
    if (wd_restore) begin
      // light-load and voltage bits are left alone
      next_ctrl1 = ccr_restore(next_ctrl1, `CCR_RST_CTRL1, `CCR_WD_MASK_CTRL1);
    end
  end

  // next charge current value; expiry keeps only the input switch bit
  always @* begin
    next_fast_charge_current_code_limit = fast_charge_current_code_limit;
    if (wr_fast_charge_current_code) begin
      next_fast_charge_current_code_limit = wdata_i;
    end
    if (wd_restore) begin
      next_fast_charge_current_code_limit = ccr_restore(next_fast_charge_current_code_limit, `CCR_RST_FAST_CHARGE_CURRENT_CODE_LIMIT,
        `CCR_WD_MASK_FAST_CHARGE_CURRENT_CODE);
    end
  end

  // next pre-charge and termination value; expiry restores it whole
  always @* begin
    next_pre_term = pre_term;
    if (wr_pre) begin
      next_pre_term = wdata_i;
    end
    if (wd_restore) begin
      next_pre_term = ccr_restore(next_pre_term, `CCR_RST_PRE_TERM,
        `CCR_WD_MASK_PRE);
    end
  end

  // register storage with register reset
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl1 <= `CCR_RST_CTRL1;
      fast_charge_current_code_limit <= `CCR_RST_FAST_CHARGE_CURRENT_CODE_LIMIT;
      pre_term <= `CCR_RST_PRE_TERM;
    end else if (reg_reset_i) begin
      ctrl1 <= `CCR_RST_CTRL1;
      fast_charge_current_code_limit <= `CCR_RST_FAST_CHARGE_CURRENT_CODE_LIMIT;
      pre_term <= `CCR_RST_PRE_TERM;
    end else begin
      ctrl1 <= next_ctrl1;
      fast_charge_current_code_limit <= next_fast_charge_current_code_limit;
      pre_term <= next_pre_term;
    end
  end

  // charge-enable pin: three flops, change taken once last two agree
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= charge_enable_pin_n_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // pre-charge code as the regulator sees it
  assign pre_clamped = ccr_clamp_pre(pre_term[7:4]);

  // charge needs bit, pin low, nonzero code and no boost
  assign chg_bit_on = ctrl1[`CCR_BIT_CHG_EN];
  assign chg_pin_on = !pin_level;
  assign chg_code_on = (fast_charge_current_code_limit[5:0] != 6'h00);
  assign boost_on = ctrl1[`CCR_BIT_BOOST_EN];
  assign chg_ok = chg_bit_on && chg_pin_on && chg_code_on && !boost_on;

  // registered outputs taken from the first control register; charge status also uses the fast-charge code and the pin
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_load_mode_disable_o <= `CCR_RST_LIGHT_LOAD;
      boost_output_active_o <= `CCR_RST_BOOST_EN;
      charge_active_o <= 1'b0;
      min_system_voltage_code_o <= `CCR_RST_MIN_SYSTEM_VOLTAGE_CODE;
      boost_low_battery_threshold_select_o <= `CCR_RST_BAT_SEL;
    end else begin
      light_load_mode_disable_o <= ctrl1[`CCR_BIT_LIGHT_LOAD];
      boost_output_active_o <= boost_on;
      charge_active_o <= chg_ok;
      min_system_voltage_code_o <= ctrl1[3:1];
      boost_low_battery_threshold_select_o <= ctrl1[0];
    end
  end

  // registered outputs taken from the charge current register
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boost_current_limit_select_o <= `CCR_RST_BOOST_CURRENT_LIMIT_SELECT;
      fast_charge_current_code_o <= `CCR_RST_FAST_CHARGE_CURRENT_CODE_CODE;
    end else begin
      boost_current_limit_select_o <= fast_charge_current_code_limit[`CCR_BIT_BOOST_CURRENT_LIMIT_SELECT];
      fast_charge_current_code_o <= fast_charge_current_code_limit[5:0];
    end
  end

  // registered outputs taken from the pre-charge and termination register
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      precharge_current_code_o <= `CCR_RST_PRE_CODE;
      termination_current_code_o <= `CCR_RST_TERM_CODE;
    end else begin
      precharge_current_code_o <= pre_clamped;
      termination_current_code_o <= pre_term[3:0];
    end
  end

  // read mux shows raw storage, unmapped addresses read zero
  always @* begin
    case (addr_i)
      `CCR_ADDR_CTRL1: begin
        rdata_o = ctrl1;
      end
      `CCR_ADDR_FAST_CHARGE_CURRENT_CODE_LIMIT: begin
        rdata_o = fast_charge_current_code_limit;
      end
      `CCR_ADDR_PRE_TERM: begin
        rdata_o = pre_term;
      end
      default: begin
        rdata_o = 8'h00;
      end
    endcase
  end

endmodule

// ===== tb/ccr_chk.sv
`timescale 1ns/1ns
module ccr_chk (
  input wire clk_i,
  input wire resetn_i,
  input wire reg_reset_i,
  input wire [7:0] addr_i,
  input wire wr_en_i,
  input wire [7:0] wdata_i,
  input wire charge_enable_pin_n_i,
  input wire watchdog_expired_o,
  input wire light_load_mode_disable_o,
  input wire boost_output_active_o,
  input wire charge_active_o,
  input wire boost_current_limit_select_o,
  input wire [5:0] fast_charge_current_code_o,
  input wire [3:0] precharge_current_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // kick write and watchdog expiry events
  sequence s_kick; wr_en_i && addr_i == 8'h01 && wdata_i[6]; endsequence
  sequence s_expire; $rose(watchdog_expired_o); endsequence
  property p_boost; boost_output_active_o |-> !charge_active_o; endproperty
  property p_zero; fast_charge_current_code_o == 6'h00 |-> !charge_active_o; endproperty
  property p_clamp; precharge_current_code_o <= 4'hc; endproperty
  property p_kick; s_kick |-> ##2 !watchdog_expired_o; endproperty
  property p_rst; reg_reset_i |-> ##2 fast_charge_current_code_o == 6'h22 && !watchdog_expired_o;
  endproperty
  property p_wd; s_expire |-> ##1 boost_current_limit_select_o; endproperty
  property p_keep; s_expire |-> ##1 $stable(light_load_mode_disable_o); endproperty
  property p_pin; charge_enable_pin_n_i [*8] |-> !charge_active_o; endproperty
  a_boost: assert property (p_boost) else $error("charge with boost");
  a_zero: assert property (p_zero) else $error("charge at zero code");
  a_clamp: assert property (p_clamp) else $error("precharge not clamped");
  a_kick: assert property (p_kick) else $error("kick ignored");
  a_rst: assert property (p_rst) else $error("register reset missed");
  a_wd: assert property (p_wd) else $error("limit not restored");
  a_keep: assert property (p_keep) else $error("light-load bit lost");
  a_pin: assert property (p_pin) else $error("charge with pin high");
endmodule
bind ccr_charger_control_registers ccr_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_reset_i(reg_reset_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .wdata_i(wdata_i),
  .charge_enable_pin_n_i(charge_enable_pin_n_i), .watchdog_expired_o(watchdog_expired_o),
  .light_load_mode_disable_o(light_load_mode_disable_o),
  .boost_output_active_o(boost_output_active_o), .charge_active_o(charge_active_o),
  .boost_current_limit_select_o(boost_current_limit_select_o),
  .fast_charge_current_code_o(fast_charge_current_code_o),
  .precharge_current_code_o(precharge_current_code_o));

// ===== tb/ccr_host.sv
`timescale 1ns/1ns
// host side: single-byte writes and reads
module ccr_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg [7:0] addr_o = 8'h00,
  output reg wr_en_o = 1'b0,
  output reg [7:0] wdata_o = 8'h00
);
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(negedge clk_i);
    wr_en_o = 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule

// ===== tb/ccr_charger_control_registers_tb.sv
`timescale 1ns/1ns
module ccr_charger_control_registers_tb;
  reg clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg reg_reset_i = 1'b0;
  reg [1:0] period = 2'h0;
  reg pin_n = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire wr_en, expired, chg;
  wire [3:0] pre;
  wire ll, boost, thr, lim;
  wire [2:0] vmin;
  wire [5:0] fcc;
  wire [3:0] term;
  reg [7:0] r [1:3];
  reg [7:0] v, a, k;
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  always #2 clk_i = ~clk_i;
  ccr_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_en_o(wr_en), .wdata_o(wdata));
  ccr_charger_control_registers #(.WDOG_UNIT_CYCLES(40'd100)) DUT (.clk_i(clk_i),
    .resetn_i(resetn_i), .reg_reset_i(reg_reset_i), .addr_i(addr), .wr_en_i(wr_en),
    .wdata_i(wdata), .rdata_o(rdata), .watchdog_period_i(period),
    .charge_enable_pin_n_i(pin_n), .watchdog_expired_o(expired),
    .light_load_mode_disable_o(ll), .boost_output_active_o(boost), .charge_active_o(chg),
    .min_system_voltage_code_o(vmin), .boost_low_battery_threshold_select_o(thr),
    .boost_current_limit_select_o(lim), .fast_charge_current_code_o(fcc),
    .precharge_current_code_o(pre), .termination_current_code_o(term));
  task chk(input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // readback of all registers and of the derived outputs
  task verify;
    repeat (8) @(posedge clk_i);
    for (k = 8'h01; k < 8'h04; k = k + 8'h01) begin
      host.rd(k, v);
      chk(v, r[k]);
    end
    chk(pre, r[3][7:4] > 4'hc ? 8'h0c : r[3][7:4]);
    chk(chg, r[1][4] & ~r[1][5] & (r[2][5:0] != 6'h00) & ~pin_n);
    chk(ll, r[1][7]);
    chk(boost, r[1][5]);
    chk(vmin, r[1][3:1]);
    chk(thr, r[1][0]);
    chk(lim, r[2][7]);
    chk(fcc, r[2][5:0]);
    chk(term, r[3][3:0]);
  endtask
  // watchdog: waits far longer than the tests take
  initial begin
    #20000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    i = $urandom(32'hc252de29);
    r[1] = 8'h1a;
    r[2] = 8'ha2;
    r[3] = 8'h22;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    host.wr(8'h04, 8'hff);
    verify;
    host.rd(8'h04, v);
    chk(v, 8'h00);
    $display("test reset done");
    for (i = 0; i < 24; i = i + 1) begin
      a = 8'(i < 3 ? i + 1 : 1 + $urandom % 3);
      v = i == 0 ? 8'h70 : i == 1 ? 8'h40 : i == 2 ? 8'hff : 8'($urandom);
      @(negedge clk_i) pin_n = $urandom;
      host.wr(a, v);
      r[a] = a == 8'h01 ? v & 8'hbf : v;
      verify;
    end
    $display("test random done");
    host.wr(8'h01, 8'h81);
    host.wr(8'h02, 8'h45);
    host.wr(8'h03, 8'h37);
    period = 2'h1;
    repeat (60) @(negedge clk_i);
    host.wr(8'h01, 8'hc1);
    repeat (60) @(negedge clk_i);
    chk(expired, 8'h00);
    repeat (60) @(negedge clk_i);
    chk(expired, 8'h01);
    period = 2'h0;
    r[1] = 8'h91;
    r[2] = 8'he2;
    r[3] = 8'h22;
    verify;
    @(negedge clk_i) reg_reset_i = 1'b1;
    @(negedge clk_i) reg_reset_i = 1'b0;
    r[1] = 8'h1a;
    r[2] = 8'ha2;
    chk(expired, 8'h00);
    verify;
    $display("test watchdog done");
    conclude;
  end
endmodule
